// >>> logic/dma_pkg.sv
// Constants and types shared by the two-channel banked byte mover.
// What this block does
// R1 - Outside the logic modes each byte moves from source to destination within two system clock cycles.
// R2 - Writing the upper length byte stalls the CPU and starts the transfer.
// R3 - Length is 15 bits; the engine moves length plus one bytes.
// R4 - Pointers are 15 bits; logical address bit 15 is always one.
// R5 - Continue mode increments per byte; FFFF wraps to 8000, bank increments.
// R6 - Reload mode advances, then restores pointer and bank when transfer stops.
// R7 - Fixed mode keeps the pointer constant for every byte.
// R8 - Mode register: source mode 1:0, destination mode 3:2, function 5:4.
// R9 - Select bit 1 picks the channel for pointer, bank, length, mode access.
// R10 - Select bit 0 picks source or destination pointer and bank.
// R11 - Physical address joins an 11-bit bank with the 15-bit pointer.
// R12 - Bank bit 15 maps the side onto internal RAM, ignoring other bank bits.
// R13 - With bank bit 15 set, logical 8000 to 807F reach control registers.
// R14 - Channel 0 function: copy, or three-cycle XOR, OR, AND combine.
// R15 - Channel 1 function 1x gives single-cycle transfers for the flash data port.
// R16 - Upper length byte reads back, so rewriting it retriggers with kept length.
// R17 - After the final write the bus is released on the next cycle.
// R18 - Logic modes read source, read destination, then write the combined byte.
package dma_pkg;
  localparam int PTR_W  = 15;
  localparam int BANK_W = 11;
  localparam int LEN_W  = 15;
  localparam int PHYS_W = 26;
  localparam int CNT_W  = 16;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;

  localparam logic [9:0] IDX_PTR_LO  = 10'h058;
  localparam logic [9:0] IDX_PTR_HI  = 10'h059;
  localparam logic [9:0] IDX_BANK_LO = 10'h05A;
  localparam logic [9:0] IDX_BANK_HI = 10'h05B;
  localparam logic [9:0] IDX_LEN_LO  = 10'h05C;
  localparam logic [9:0] IDX_LEN_HI  = 10'h05D;
  localparam logic [9:0] IDX_SELECT  = 10'h05E;
  localparam logic [9:0] IDX_MODE    = 10'h05F;

  localparam logic [7:0] PTRH_MASK  = 8'h7F;
  localparam logic [7:0] BANKH_MASK = 8'h87;
  localparam logic [7:0] SEL_MASK   = 8'h03;
  localparam logic [7:0] MODE_MASK  = 8'h3F;
  localparam logic [15:0] REG_RESET = 16'h0000;

  localparam int BANK_SW_BIT  = 15;
  localparam int SEL_CH_BIT   = 1;
  localparam int SEL_SIDE_BIT = 0;
  localparam int MODE_SRC_LSB = 0;
  localparam int MODE_DST_LSB = 2;
  localparam int MODE_FN_LSB  = 4;
  localparam int FIXED_BIT    = 1;
  localparam int FAST_BIT     = 1;

  localparam logic [1:0] PM_CONT   = 2'h0;
  localparam logic [1:0] PM_RELOAD = 2'h1;
  localparam logic [1:0] FN_NORMAL = 2'h0;
  localparam logic [1:0] FN_XOR    = 2'h1;
  localparam logic [1:0] FN_OR     = 2'h2;
  localparam logic [1:0] FN_AND    = 2'h3;
  localparam logic [14:0] CTRL_LAST = 15'h007F;

  localparam int CLK_MHZ  = 100;
  localparam int BYTE_NS  = 20;
  localparam int BYTE_CYC = BYTE_NS * CLK_MHZ / 1000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RD_SRC = 3'h1,
    ST_RD_DST = 3'h2,
    ST_WR     = 3'h3,
    ST_FAST   = 3'h4
  } state_t;

  typedef enum logic [1:0] {
    SP_PHYS = 2'h0,
    SP_RAM  = 2'h1,
    SP_CTRL = 2'h2
  } space_t;
endpackage : dma_pkg

// >>> logic/byte_fifo.sv
// Byte FIFO between the read and the write side of the mover.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_t;

  fifo_t f;
  fifo_t next_f;
  logic  push;
  logic  pop;

  assign in_ready  = f.cnt != (AW+1)'(D);
  assign out_valid = f.cnt != '0;
  assign out_data  = f.mem[f.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_f = f;
    if (push) begin
      next_f.mem[f.wp] = in_data;
      next_f.wp = (f.wp == AW'(D-1)) ? '0 : f.wp + 1'b1;
    end
    if (pop) begin
      next_f.rp = (f.rp == AW'(D-1)) ? '0 : f.rp + 1'b1;
    end
    next_f.cnt = f.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge clk) disable iff (!arst_n)
    f.cnt <= (AW+1)'(D)) else $error("FIFO count passed its depth");
endmodule : byte_fifo
`default_nettype wire

// >>> logic/ptr_step.sv
// Next pointer and bank of one transfer side after a byte.
`timescale 1ns/1ps
`default_nettype none
module ptr_step (
  input  wire logic [14:0] ptr,
  input  wire logic [15:0] bank,
  input  wire logic [1:0]  mode,
  output logic [14:0]      next_ptr,
  output logic [15:0]      next_bank
);
  logic [15:0] sum;

  assign sum = {1'b0, ptr} + 16'h0001;

  always_comb begin
    next_ptr  = ptr;
    next_bank = bank;
    // R7 - fixed holds pointer
    if (!mode[dma_pkg::FIXED_BIT]) begin
      // R5 - wrap and bank step
      next_ptr = sum[14:0];
      if (sum[dma_pkg::PTR_W]) begin
        next_bank[10:0] = bank[10:0] + 11'h001;
      end
    end
  end
endmodule : ptr_step
`default_nettype wire

// >>> logic/banked_dma.sv
// Two-channel banked byte mover with APB registers and a byte bus master.
`timescale 1ns/1ps
`default_nettype none
module banked_dma #(
  parameter int FIFO_D = dma_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cpu_hold,
  output logic             rd_en,
  output logic [25:0]      rd_addr,
  output logic [1:0]       rd_space,
  input  wire logic [7:0]  rd_data,
  output logic             wr_en,
  output logic [25:0]      wr_addr,
  output logic [1:0]       wr_space,
  output logic [7:0]       wr_data
);
  typedef struct packed {
    dma_pkg::state_t        st;
    logic [1:0]             sel;
    logic                   ch;
    logic [1:0][1:0][14:0]  ptr;
    logic [1:0][1:0][15:0]  bank;
    logic [1:0][14:0]       len;
    logic [1:0][5:0]        mode;
    logic [1:0][14:0]       cptr;
    logic [1:0][15:0]       cbank;
    logic [15:0]            rleft;
    logic [15:0]            wleft;
    logic [7:0]             dbuf;
  } regs_t;

  regs_t       s;
  regs_t       next_s;
  logic [9:0]  idx;
  logic        hit;
  logic        wr_acc;
  logic        busy;
  logic [5:0]  am;
  logic [1:0]  smode;
  logic [1:0]  dmode;
  logic [1:0]  fn;
  logic        logic_mode;
  logic        fast;
  logic        rd_dst_side;
  logic        f_in_valid;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [7:0]  f_out_data;
  logic [14:0] adv_ptr_src;
  logic [15:0] adv_bank_src;
  logic [14:0] adv_ptr_dst;
  logic [15:0] adv_bank_dst;
  logic [27:0] rmap;
  logic [27:0] wmap;
  logic [7:0]  rbyte;
  logic        last_wr;
  logic [14:0] new_len;

  // Bank bit 15 picks internal RAM; its low 128 bytes are control registers.
  function automatic logic [27:0] map_addr(input logic [15:0] bank, input logic [14:0] ptr);
    logic [1:0] sp;
    logic [25:0] a;
    sp = dma_pkg::SP_PHYS;
    a = {bank[10:0], ptr};
    // R12 - internal RAM window
    if (bank[dma_pkg::BANK_SW_BIT]) begin
      a = {11'h000, ptr};
      // R13 - control register window
      sp = (ptr <= dma_pkg::CTRL_LAST) ? dma_pkg::SP_CTRL : dma_pkg::SP_RAM;
    end
    return {sp, a};
  endfunction : map_addr

  assign busy     = s.st != dma_pkg::ST_IDLE;
  assign cpu_hold = busy;
  assign idx      = paddr[11:2];
  assign hit      = (paddr[1:0] == 2'h0) && (idx >= dma_pkg::IDX_PTR_LO)
                    && (idx <= dma_pkg::IDX_MODE);
  // R2 - CPU accesses wait while busy
  assign pready   = !busy;
  assign pslverr  = psel && penable && !hit;
  assign wr_acc   = psel && penable && pready && pwrite && hit && pstrb[0];

  // R8 - mode field split
  assign am         = s.mode[s.ch];
  assign smode      = am[dma_pkg::MODE_SRC_LSB +: 2];
  assign dmode      = am[dma_pkg::MODE_DST_LSB +: 2];
  assign fn         = am[dma_pkg::MODE_FN_LSB +: 2];
  assign logic_mode = !s.ch && (fn != dma_pkg::FN_NORMAL);
  // R15 - channel 1 single cycle
  assign fast       = s.ch && fn[dma_pkg::FAST_BIT];

  // R1 - read one cycle, write the next
  always_comb begin
    rd_en = 1'b0;
    case (s.st)
      dma_pkg::ST_RD_SRC: rd_en = f_in_ready;
      dma_pkg::ST_RD_DST: rd_en = 1'b1;
      dma_pkg::ST_FAST:   rd_en = (s.rleft != 16'h0000) && f_in_ready;
      default:            rd_en = 1'b0;
    endcase
  end

  assign wr_en       = ((s.st == dma_pkg::ST_WR) || (s.st == dma_pkg::ST_FAST)) && f_out_valid;
  assign f_in_valid  = rd_en && (s.st != dma_pkg::ST_RD_DST);
  assign rd_dst_side = s.st == dma_pkg::ST_RD_DST;
  assign last_wr     = wr_en && (s.wleft == 16'h0001);

  // R11 - bank and pointer form the address
  assign rmap     = map_addr(s.cbank[rd_dst_side], s.cptr[rd_dst_side]);
  assign wmap     = map_addr(s.cbank[1], s.cptr[1]);
  assign rd_addr  = rmap[25:0];
  assign rd_space = rmap[27:26];
  assign wr_addr  = wmap[25:0];
  assign wr_space = wmap[27:26];

  // R14 - combine source with destination
  always_comb begin
    wr_data = f_out_data;
    if (logic_mode) begin
      case (fn)
        dma_pkg::FN_XOR: wr_data = f_out_data ^ s.dbuf;
        dma_pkg::FN_OR:  wr_data = f_out_data | s.dbuf;
        dma_pkg::FN_AND: wr_data = f_out_data & s.dbuf;
        default:         wr_data = f_out_data;
      endcase
    end
  end

  byte_fifo #(
    .W (dma_pkg::DATA_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (rd_data),
    .out_valid (f_out_valid),
    .out_ready (wr_en),
    .out_data  (f_out_data)
  );

  ptr_step u_src_step (
    .ptr       (s.cptr[0]),
    .bank      (s.cbank[0]),
    .mode      (smode),
    .next_ptr  (adv_ptr_src),
    .next_bank (adv_bank_src)
  );

  ptr_step u_dst_step (
    .ptr       (s.cptr[1]),
    .bank      (s.cbank[1]),
    .mode      (dmode),
    .next_ptr  (adv_ptr_dst),
    .next_bank (adv_bank_dst)
  );

  // R9 - channel picked by select bit 1
  // R10 - side picked by select bit 0
  always_comb begin
    rbyte = 8'h00;
    case (idx)
      dma_pkg::IDX_PTR_LO:  rbyte = s.ptr[s.sel[1]][s.sel[0]][7:0];
      dma_pkg::IDX_PTR_HI:  rbyte = {1'b0, s.ptr[s.sel[1]][s.sel[0]][14:8]};
      dma_pkg::IDX_BANK_LO: rbyte = s.bank[s.sel[1]][s.sel[0]][7:0];
      dma_pkg::IDX_BANK_HI: rbyte = s.bank[s.sel[1]][s.sel[0]][15:8] & dma_pkg::BANKH_MASK;
      dma_pkg::IDX_LEN_LO:  rbyte = s.len[s.sel[1]][7:0];
      // R16 - upper length byte reads back
      dma_pkg::IDX_LEN_HI:  rbyte = {1'b0, s.len[s.sel[1]][14:8]};
      dma_pkg::IDX_SELECT:  rbyte = {6'h00, s.sel};
      dma_pkg::IDX_MODE:    rbyte = {2'h0, s.mode[s.sel[1]]};
      default:              rbyte = 8'h00;
    endcase
  end
  assign prdata  = {24'h000000, hit ? rbyte : 8'h00};
  assign new_len = {pwdata[6:0], s.len[s.sel[1]][7:0]};

  always_comb begin
    next_s = s;
    if (wr_acc) begin
      case (idx)
        dma_pkg::IDX_PTR_LO:  next_s.ptr[s.sel[1]][s.sel[0]][7:0] = pwdata[7:0];
        // R4 - fifteen-bit pointer
        dma_pkg::IDX_PTR_HI:
          next_s.ptr[s.sel[1]][s.sel[0]][14:8] = pwdata[6:0] & dma_pkg::PTRH_MASK[6:0];
        dma_pkg::IDX_BANK_LO: next_s.bank[s.sel[1]][s.sel[0]][7:0] = pwdata[7:0];
        dma_pkg::IDX_BANK_HI:
          next_s.bank[s.sel[1]][s.sel[0]][15:8] = pwdata[7:0] & dma_pkg::BANKH_MASK;
        dma_pkg::IDX_LEN_LO:  next_s.len[s.sel[1]][7:0] = pwdata[7:0];
        dma_pkg::IDX_LEN_HI: begin
          // R2 - trigger write starts the channel
          // R3 - length plus one bytes
          next_s.len[s.sel[1]] = new_len;
          next_s.ch = s.sel[dma_pkg::SEL_CH_BIT];
          next_s.cptr = s.ptr[s.sel[1]];
          next_s.cbank = s.bank[s.sel[1]];
          next_s.rleft = {1'b0, new_len} + 16'h0001;
          next_s.wleft = {1'b0, new_len} + 16'h0001;
          next_s.st = (s.sel[1] && s.mode[1][dma_pkg::MODE_FN_LSB + dma_pkg::FAST_BIT])
                      ? dma_pkg::ST_FAST : dma_pkg::ST_RD_SRC;
        end
        dma_pkg::IDX_SELECT:  next_s.sel = pwdata[1:0] & dma_pkg::SEL_MASK[1:0];
        dma_pkg::IDX_MODE:    next_s.mode[s.sel[1]] = pwdata[5:0] & dma_pkg::MODE_MASK[5:0];
        default:              next_s.sel = s.sel;
      endcase
    end
    if (rd_en && f_in_valid) begin
      next_s.cptr[0] = adv_ptr_src;
      next_s.cbank[0] = adv_bank_src;
      next_s.rleft = s.rleft - 16'h0001;
    end
    if (wr_en) begin
      next_s.cptr[1] = adv_ptr_dst;
      next_s.cbank[1] = adv_bank_dst;
      next_s.wleft = s.wleft - 16'h0001;
    end
    case (s.st)
      dma_pkg::ST_RD_SRC: begin
        // R18 - source read, then destination read
        if (rd_en) begin
          next_s.st = logic_mode ? dma_pkg::ST_RD_DST : dma_pkg::ST_WR;
        end
      end
      dma_pkg::ST_RD_DST: begin
        next_s.dbuf = rd_data;
        next_s.st = dma_pkg::ST_WR;
      end
      dma_pkg::ST_WR: begin
        if (wr_en) begin
          next_s.st = dma_pkg::ST_RD_SRC;
        end
      end
      default: next_s.dbuf = s.dbuf;
    endcase
    if (last_wr) begin
      // R17 - release on the next cycle
      next_s.st = dma_pkg::ST_IDLE;
      // R6 - reload keeps the start values
      if (smode != dma_pkg::PM_RELOAD) begin
        next_s.ptr[s.ch][0] = adv_ptr_src;
        next_s.bank[s.ch][0] = adv_bank_src;
        if (!(rd_en && f_in_valid)) begin
          next_s.ptr[s.ch][0] = s.cptr[0];
          next_s.bank[s.ch][0] = s.cbank[0];
        end
      end
      if (dmode != dma_pkg::PM_RELOAD) begin
        next_s.ptr[s.ch][1] = adv_ptr_dst;
        next_s.bank[s.ch][1] = adv_bank_dst;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.st <= dma_pkg::ST_IDLE;
      s.len <= {2{dma_pkg::REG_RESET[14:0]}};
    end else begin
      s <= next_s;
    end
  end

  // Bytes written during the current transfer, read only by the checks below.
  logic [15:0] wcnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wcnt <= 16'h0000;
    end else if (!busy) begin
      wcnt <= 16'h0000;
    end else if (wr_en) begin
      wcnt <= wcnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_src_read;
    rd_en && s.st == dma_pkg::ST_RD_SRC && logic_mode;
  endsequence
  sequence s_dst_read;
    rd_en && rd_dst_side;
  endsequence

  chk_trigger_starts: assert property ( // R2
    wr_acc && idx == dma_pkg::IDX_LEN_HI |=> busy && !pready)
    else $error("Length high write did not start the engine");
  chk_byte_two: assert property ( // R1
    rd_en && s.st == dma_pkg::ST_RD_SRC && !logic_mode |=> wr_en)
    else $error("Byte not written on the cycle after its read");
  chk_byte_count: assert property ( // R3
    last_wr |=> !busy && wcnt == {1'b0, $past(s.len[s.ch])} + 16'h0001)
    else $error("Transfer wrote a wrong number of bytes");
  chk_logic_three: assert property ( // R18
    s_src_read |=> s_dst_read ##1 wr_en)
    else $error("Logic mode skipped a step");
  chk_fixed_src: assert property ( // R7
    busy && smode[dma_pkg::FIXED_BIT] |=> s.cptr[0] == $past(s.cptr[0]))
    else $error("Fixed source pointer moved");
  chk_cont_step: assert property ( // R5
    wr_en && dmode == dma_pkg::PM_CONT |=> s.cptr[1] == $past(s.cptr[1]) + 15'h0001)
    else $error("Continue destination pointer did not step by one");
  chk_ram_map: assert property ( // R12
    wr_en && wr_space != dma_pkg::SP_PHYS |-> wr_addr[25:15] == 11'h000)
    else $error("Internal RAM access carried bank bits");
  chk_ctrl_map: assert property ( // R13
    rd_en && s.cbank[rd_dst_side][dma_pkg::BANK_SW_BIT]
      && s.cptr[rd_dst_side] <= dma_pkg::CTRL_LAST |-> rd_space == dma_pkg::SP_CTRL)
    else $error("Control window not mapped to control registers");
  chk_reload_back: assert property ( // R6
    last_wr && dmode == dma_pkg::PM_RELOAD |=> s.ptr[$past(s.ch)][1] == $past(s.ptr[s.ch][1]))
    else $error("Reload destination pointer not restored");
  chk_release_next: assert property ( // R17
    last_wr |=> !cpu_hold && pready)
    else $error("Bus not released after the final byte");
  chk_wrap_bank: assert property ( // R5
    rd_en && f_in_valid && smode == dma_pkg::PM_CONT && s.cptr[0] == 15'h7FFF
      |=> s.cptr[0] == 15'h0000 && s.cbank[0][10:0] == $past(s.cbank[0][10:0]) + 11'h001)
    else $error("Source pointer wrap did not step the bank");
  chk_fast_mode: assert property ( // R15
    busy && fast |-> s.st == dma_pkg::ST_FAST)
    else $error("Channel 1 single-cycle mode not in use");
  chk_phys_join: assert property ( // R11
    wr_en && !s.cbank[1][dma_pkg::BANK_SW_BIT] |-> wr_space == dma_pkg::SP_PHYS
      && wr_addr == {s.cbank[1][10:0], s.cptr[1]})
    else $error("Physical write address lost its bank");
endmodule : banked_dma
`default_nettype wire

// >>> tb/mem_model.sv
// Byte memory on the far side of the mover's bus master.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic        clk,
  input  wire logic        rd_en,
  input  wire logic [25:0] rd_addr,
  input  wire logic [1:0]  rd_space,
  output logic [7:0]       rd_data,
  input  wire logic        wr_en,
  input  wire logic [25:0] wr_addr,
  input  wire logic [1:0]  wr_space,
  input  wire logic [7:0]  wr_data
);
  logic [7:0] mem [logic [27:0]];

  // Unwritten bytes hold a pattern derived from their address bits alone.
  function automatic logic [7:0] look(input logic [27:0] k);
    return mem.exists(k) ? mem[k] : (k[7:0] ^ k[22:15] ^ 8'h3C);
  endfunction : look

  logic [7:0] idle_val = 8'h00;

  // Read data follows the address at once; off the bus the lines toggle each cycle.
  always @(negedge clk) idle_val <= ~idle_val;
  assign rd_data = rd_en ? look({rd_space, rd_addr}) : idle_val;

  always @(posedge clk) begin
    if (wr_en === 1'b1) begin
      mem[{wr_space, wr_addr}] = wr_data;
    end
  end
endmodule : mem_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the two-channel banked byte mover.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, cpu_hold;
  logic        rd_en, wr_en, rd_seen, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [25:0] rd_addr, wr_addr, rd0_addr;
  logic [1:0]  rd_space, wr_space, rd0_space;
  logic [7:0]  rd_data, wr_data, rq, ex;
  int          mismatches, n_checks, hold_cyc, wr_cnt;

  banked_dma u_banked_dma (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_hold(cpu_hold), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_space(rd_space), .rd_data(rd_data), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_space(wr_space), .wr_data(wr_data));
  mem_model u_mem_model (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_space(rd_space),
    .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_space(wr_space),
    .wr_data(wr_data));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (cpu_hold === 1'b1) hold_cyc++;
    if (wr_en === 1'b1) wr_cnt++;
    if (rd_en === 1'b1 && !rd_seen) begin
      rd_seen = 1'b1;
      rd0_addr = rd_addr;
      rd0_space = rd_space;
    end
  end

  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  function automatic logic [27:0] pk(input logic [15:0] b, input logic [14:0] p);
    return {2'b00, b[10:0], p};
  endfunction : pk

  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 70000);
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    rq = prdata[7:0];
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic side(input logic ch, input logic s, input logic [14:0] p,
                      input logic [15:0] b);
    apb(1'b1, dma_pkg::IDX_SELECT, {6'h00, ch, s});
    apb(1'b1, dma_pkg::IDX_PTR_LO, p[7:0]);
    apb(1'b1, dma_pkg::IDX_PTR_HI, {1'b0, p[14:8]});
    apb(1'b1, dma_pkg::IDX_BANK_LO, b[7:0]);
    apb(1'b1, dma_pkg::IDX_BANK_HI, b[15:8]);
  endtask : side

  task automatic chkside(input logic ch, input logic s, input logic [14:0] ep,
                         input logic [15:0] eb);
    logic [7:0] lo;
    apb(1'b1, dma_pkg::IDX_SELECT, {6'h00, ch, s});
    apb(1'b0, dma_pkg::IDX_PTR_LO, 8'h00);
    lo = rq;
    apb(1'b0, dma_pkg::IDX_PTR_HI, 8'h00);
    `CHK("pointer", ep, {rq[6:0], lo})
    apb(1'b0, dma_pkg::IDX_BANK_LO, 8'h00);
    lo = rq;
    apb(1'b0, dma_pkg::IDX_BANK_HI, 8'h00);
    `CHK("bank", eb, {rq, lo})
  endtask : chkside

  task automatic xfer(input logic ch, input logic [7:0] md, input logic [14:0] sp,
                      input logic [15:0] sb, input logic [14:0] dp, input logic [15:0] db,
                      input logic [14:0] len, input int cyc);
    int n;
    side(ch, 1'b0, sp, sb);
    side(ch, 1'b1, dp, db);
    apb(1'b1, dma_pkg::IDX_MODE, md);
    apb(1'b1, dma_pkg::IDX_LEN_LO, len[7:0]);
    hold_cyc = 0;
    wr_cnt = 0;
    rd_seen = 1'b0;
    apb(1'b1, dma_pkg::IDX_LEN_HI, {1'b0, len[14:8]});
    @(negedge clk);
    `CHK("stall", 1'b0, pready) // bus stall
    n = 0;
    while (cpu_hold !== 1'b0 && n < 70000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 70000) begin
      mismatches++;
      complete_run();
    end
    @(posedge clk);
    `CHK("busy cycles", cyc, hold_cyc) // byte timing
    `CHK("bytes written", int'(len) + 1, wr_cnt) // length plus one
    apb(1'b0, dma_pkg::IDX_LEN_HI, 8'h00);
    `CHK("length high", {1'b0, len[14:8]}, rq) // readable trigger
  endtask : xfer

  task automatic s_regs();
    for (int i = 'h58; i <= 'h5F; i++) begin
      apb(1'b0, i[9:0], 8'h00);
      `CHK("reset value", 8'h00, rq) // register map
    end
    apb(1'b1, 10'h060, 8'hFF);
    `CHK("unmapped error", 1'b1, rerr) // register map
    apb(1'b0, 10'h060, 8'h00);
    `CHK("unmapped data", 8'h00, rq) // register map
    apb(1'b1, dma_pkg::IDX_PTR_HI, 8'hFF);
    apb(1'b0, dma_pkg::IDX_PTR_HI, 8'h00);
    `CHK("pointer high mask", 8'h7F, rq) // fifteen bits
  endtask : s_regs

  task automatic s_copy();
    xfer(1'b0, 8'h00, 15'h0010, 16'h0001, 15'h0100, 16'h0002, 15'd3, 8);
    `CHK("physical address", {11'h001, 15'h0010}, rd0_addr) // bank join
    for (int i = 0; i < 4; i++) begin
      ex = u_mem_model.look(pk(16'h0001, 15'h0010 + 15'(i)));
      `CHK("copied byte", ex, u_mem_model.look(pk(16'h0002, 15'h0100 + 15'(i))))
    end
    chkside(1'b0, 1'b0, 15'h0014, 16'h0001); // continue source
    chkside(1'b0, 1'b1, 15'h0104, 16'h0002); // continue dest
  endtask : s_copy

  task automatic s_wrap();
    xfer(1'b0, 8'h08, 15'h7FFE, 16'h0005, 15'h0300, 16'h0003, 15'd3, 8);
    chkside(1'b0, 1'b0, 15'h0002, 16'h0006); // wrap and bank step
    chkside(1'b0, 1'b1, 15'h0300, 16'h0003); // fixed pointer
    ex = u_mem_model.look(pk(16'h0006, 15'h0001));
    `CHK("fixed dest", ex, u_mem_model.look(pk(16'h0003, 15'h0300))) // same place
  endtask : s_wrap

  task automatic s_reload();
    xfer(1'b0, 8'h05, 15'h7FFF, 16'h0007, 15'h1000, 16'h0001, 15'd2, 6);
    chkside(1'b0, 1'b0, 15'h7FFF, 16'h0007); // reload source
    chkside(1'b0, 1'b1, 15'h1000, 16'h0001); // reload dest
  endtask : s_reload

  task automatic s_logic();
    logic [7:0] a, b;
    for (int f = 1; f < 4; f++) begin
      a = u_mem_model.look(pk(16'h000A, 15'h0020));
      b = u_mem_model.look(pk(16'h000B, 15'h0040 + 15'(f)));
      ex = (f == 1) ? (a ^ b) : (f == 2) ? (a | b) : (a & b);
      xfer(1'b0, {2'b00, f[1:0], 4'h0}, 15'h0020, 16'h000A, 15'h0040 + 15'(f), 16'h000B,
           15'd0, 3); // three cycles
      `CHK("combined", ex, u_mem_model.look(pk(16'h000B, 15'h0040 + 15'(f))))
    end
  endtask : s_logic

  task automatic s_fast();
    xfer(1'b1, 8'h20, 15'h0000, 16'h0010, 15'h0050, 16'h0011, 15'd3, 5); // single cycle
    ex = u_mem_model.look(pk(16'h0010, 15'h0003));
    `CHK("fast byte", ex, u_mem_model.look(pk(16'h0011, 15'h0053)))
    apb(1'b1, dma_pkg::IDX_SELECT, 8'h00);
    apb(1'b0, dma_pkg::IDX_MODE, 8'h00);
    `CHK("channel mode", 8'h30, rq) // own mode
  endtask : s_fast

  task automatic s_space();
    xfer(1'b0, 8'h00, 15'h0040, 16'h8000, 15'h0600, 16'h0001, 15'd0, 2);
    `CHK("control space", dma_pkg::SP_CTRL, rd0_space) // control window
    xfer(1'b0, 8'h00, 15'h0080, 16'h87FF, 15'h0600, 16'h0001, 15'd0, 2);
    `CHK("ram space", dma_pkg::SP_RAM, rd0_space) // internal RAM
    `CHK("ram offset", 26'h0000080, rd0_addr) // bank bits ignored
  endtask : s_space

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    rd_seen = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    s_regs();
    s_copy();
    s_wrap();
    s_reload();
    s_logic();
    s_fast();
    s_space();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
